// *** rtl/interval_counter_pkg.sv ***
// package: register map, field layout and constants of the dual 8-bit interval/event counter
package interval_counter_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [4:0] OFS_MODE_CTRL_A  = 5'h00;
  localparam logic [4:0] OFS_MODE_CTRL_B  = 5'h04;
  localparam logic [4:0] OFS_COMPARE_A    = 5'h08;
  localparam logic [4:0] OFS_COMPARE_B    = 5'h0C;
  localparam logic [4:0] OFS_COUNTER_A    = 5'h10;
  localparam logic [4:0] OFS_COUNTER_B    = 5'h14;
  localparam logic [4:0] OFS_IRQ_STATUS   = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK     = 5'h1C;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int         POS_COUNT_ENABLE = 7;
  localparam int         POS_CLOCK_SEL    = 8;
  localparam logic [7:0] RST_MODE_CTRL    = 8'h00;
  localparam logic [3:0] RST_CLOCK_SEL    = 4'h0;
  localparam logic [7:0] RST_COMPARE      = 8'h00;
  localparam logic [7:0] RST_COUNTER      = 8'h00;
  localparam logic [1:0] RST_IRQ          = 2'h0;

  // ****************************************
  // clock select codes
  // ****************************************
  localparam logic [3:0] SEL_EVENT_RISE   = 4'h0;
  localparam logic [3:0] SEL_EVENT_FALL   = 4'h1;
  localparam logic [3:0] SEL_DIV_FIRST    = 4'h4;
  localparam logic [3:0] SEL_DIV_LAST     = 4'hE;
  localparam logic [3:0] SEL_DIV_4096     = 4'hF;
  localparam int         LOG2_DIV_4096    = 12;
  localparam int         PRESCALE_W       = 12;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  // ****************************************
  // per-channel settings carrier
  // ****************************************
  typedef struct packed {
    logic       count_enable;
    logic [6:0] output_ctrl;
    logic [3:0] clock_sel;
  } chan_cfg_type;

endpackage : interval_counter_pkg

// *** rtl/interval_event_counter.sv ***
// dual 8-bit interval timer / external event counter with Avalon-MM slave
// Notes on behaviour
// - interval mode raises match interrupt repeatedly each compare-defined period
// - on counter equal compare, next count clock clears to 0 and flags interrupt
// - each channel has its own independent 4-bit clock select field
// - codes 0000 and 0001 count edges of the external event input
// - codes 0100..1110 divide by 1..1024, 1111 by 4096; scale bit halves
// - scale choice comes from bit 0 of external oscillation mode register
// - interval spans 1 to 256 count clocks, one count clock resolution
// - event mode increments counter once per valid input edge
// - code 0000 counts rising edges, code 0001 falling edges
// - output control bits stay writable and readable while counting
// - clearing count enable stops and zeroes counter; setting allows counting
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps

module interval_event_counter #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // oscillation mode register bit 0 from clock system
  input  wire logic        osc_scale_bit,
  // external event pins
  input  wire logic        event_in_a,
  input  wire logic        event_in_b,
  // interrupts
  output logic             match_irq_a,
  output logic             match_irq_b,
  output logic             irq
);

  // ****************************************
  // declarations
  // ****************************************
  interval_counter_pkg::chan_cfg_type cfg_reg [CHANNELS];
  logic [7:0]  compare_reg [CHANNELS];
  logic [7:0]  counter_reg [CHANNELS];
  logic [CHANNELS-1:0] status_reg;
  logic [CHANNELS-1:0] mask_reg;
  logic [CHANNELS-1:0] match_pulse;
  logic [CHANNELS-1:0] tick;
  logic [CHANNELS-1:0] ev_meta_reg;
  logic [CHANNELS-1:0] ev_sync_reg;
  logic [CHANNELS-1:0] ev_prev_reg;
  logic [CHANNELS-1:0] ev_pins;
  logic [interval_counter_pkg::PRESCALE_W-1:0] prescale_reg;
  logic [interval_counter_pkg::PRESCALE_W-1:0] prescale_prev_reg;
  logic        scale_meta_reg;
  logic        scale_sync_reg;
  logic        ack_reg;
  logic        wr_hit;
  logic [31:0] read_next;

  localparam int PRESCALE_W_L = interval_counter_pkg::PRESCALE_W;

  assign ev_pins = {event_in_b, event_in_a};

  // log2 of the count clock divider; -1 means no internal clock
  function automatic int tap_of(input logic [3:0] sel, input logic scale);
    int tap;
    tap = -1;
    if (sel >= interval_counter_pkg::SEL_DIV_FIRST && sel <= interval_counter_pkg::SEL_DIV_LAST)
      tap = int'(sel - interval_counter_pkg::SEL_DIV_FIRST) - int'(scale);
    else if (sel == interval_counter_pkg::SEL_DIV_4096)
      tap = interval_counter_pkg::LOG2_DIV_4096 - int'(scale);
    return tap;
  endfunction : tap_of

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_meta_reg    <= '0;
      ev_sync_reg    <= '0;
      ev_prev_reg    <= '0;
      scale_meta_reg <= 1'b0;
      scale_sync_reg <= 1'b0;
    end else begin
      ev_meta_reg    <= ev_pins;
      ev_sync_reg    <= ev_meta_reg;
      ev_prev_reg    <= ev_sync_reg;
      scale_meta_reg <= osc_scale_bit;
      scale_sync_reg <= scale_meta_reg;
    end
  end

  // ****************************************
  // shared prescaler
  // ****************************************
  // free running so both channels share one divider; a start may lose up to one count clock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prescale_reg      <= '0;
      prescale_prev_reg <= '0;
    end else begin
      prescale_reg      <= prescale_reg + 1'b1;
      prescale_prev_reg <= prescale_reg;
    end
  end

  // ****************************************
  // count clock select and counters
  // ****************************************
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    logic [3:0] sel;
    int         tap;
    assign sel = cfg_reg[ch].clock_sel;

    always_comb begin
      tap      = tap_of(sel, scale_sync_reg);
      tick[ch] = 1'b0;
      case (sel)
        interval_counter_pkg::SEL_EVENT_RISE:
          tick[ch] = ev_sync_reg[ch] & ~ev_prev_reg[ch];
        interval_counter_pkg::SEL_EVENT_FALL:
          tick[ch] = ~ev_sync_reg[ch] & ev_prev_reg[ch];
        default: begin
          // tap 0 counts every cycle; tap k on each falling edge of prescaler bit k-1
          if (tap == 0)
            tick[ch] = 1'b1;
          else if (tap > 0 && tap <= PRESCALE_W_L)
            tick[ch] = prescale_prev_reg[tap-1] & ~prescale_reg[tap-1];
        end
      endcase
    end

    // counter clears on count clock after match, so period is compare+1 ticks
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        counter_reg[ch] <= interval_counter_pkg::RST_COUNTER;
        match_pulse[ch] <= 1'b0;
      end else if (!cfg_reg[ch].count_enable) begin
        counter_reg[ch] <= interval_counter_pkg::RST_COUNTER;
        match_pulse[ch] <= 1'b0;
      end else if (tick[ch]) begin
        if (counter_reg[ch] == compare_reg[ch]) begin
          counter_reg[ch] <= interval_counter_pkg::RST_COUNTER;
          match_pulse[ch] <= 1'b1;
        end else begin
          counter_reg[ch] <= counter_reg[ch] + 8'h01;
          match_pulse[ch] <= 1'b0;
        end
      end else begin
        match_pulse[ch] <= 1'b0;
      end
    end

    // tick: with code 0100 and scale 1 is prohibited and yields no count
  end

  // ****************************************
  // register writes
  // ****************************************
  // a write lands only at the edge where the master sees waitrequest low
  assign wr_hit = avs_write & ack_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cfg_reg[i].count_enable <= 1'b0;
        cfg_reg[i].output_ctrl  <= interval_counter_pkg::RST_MODE_CTRL[6:0];
        cfg_reg[i].clock_sel    <= interval_counter_pkg::RST_CLOCK_SEL;
        compare_reg[i]          <= interval_counter_pkg::RST_COMPARE;
      end
      mask_reg <= interval_counter_pkg::RST_IRQ;
    end else if (wr_hit) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (avs_address == interval_counter_pkg::OFS_MODE_CTRL_A + 5'(4 * i)) begin
          if (avs_byteenable[0]) begin
            cfg_reg[i].count_enable <= avs_writedata[interval_counter_pkg::POS_COUNT_ENABLE];
            cfg_reg[i].output_ctrl  <= avs_writedata[6:0];
          end
          if (avs_byteenable[1])
            cfg_reg[i].clock_sel <= avs_writedata[interval_counter_pkg::POS_CLOCK_SEL +: 4];
        end
        if (avs_address == interval_counter_pkg::OFS_COMPARE_A + 5'(4 * i) && avs_byteenable[0])
          compare_reg[i] <= avs_writedata[7:0];
      end
      if (avs_address == interval_counter_pkg::OFS_IRQ_MASK && avs_byteenable[0])
        mask_reg <= avs_writedata[CHANNELS-1:0];
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  // set beats a simultaneous write-one clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= interval_counter_pkg::RST_IRQ;
    end else begin
      if (wr_hit && avs_address == interval_counter_pkg::OFS_IRQ_STATUS && avs_byteenable[0])
        status_reg <= (status_reg & ~avs_writedata[CHANNELS-1:0]) | match_pulse;
      else
        status_reg <= status_reg | match_pulse;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
      irq         <= 1'b0;
    end else begin
      match_irq_a <= match_pulse[0];
      match_irq_b <= match_pulse[1];
      irq         <= |(status_reg & mask_reg);
    end
  end

  // ****************************************
  // bus answer: one wait cycle, then ack
  // ****************************************
  always_comb begin
    read_next = interval_counter_pkg::UNMAPPED_DATA;
    for (int i = 0; i < CHANNELS; i++) begin
      if (avs_address == interval_counter_pkg::OFS_MODE_CTRL_A + 5'(4 * i))
        read_next = {20'h00000, cfg_reg[i].clock_sel, cfg_reg[i].count_enable,
                     cfg_reg[i].output_ctrl};
      if (avs_address == interval_counter_pkg::OFS_COMPARE_A + 5'(4 * i))
        read_next = {24'h000000, compare_reg[i]};
      if (avs_address == interval_counter_pkg::OFS_COUNTER_A + 5'(4 * i))
        read_next = {24'h000000, counter_reg[i]};
    end
    if (avs_address == interval_counter_pkg::OFS_IRQ_STATUS)
      read_next = {30'h00000000, status_reg};
    if (avs_address == interval_counter_pkg::OFS_IRQ_MASK)
      read_next = {30'h00000000, mask_reg};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg      <= (avs_read | avs_write) & ~ack_reg;
      avs_readdata <= (avs_read & ~ack_reg) ? read_next : avs_readdata;
    end
  end

  // waitrequest high while idle, dropped for the acknowledging cycle
  always_ff @(posedge ref_clk) begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg);
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_disabled_zero;
    @(posedge ref_clk) disable iff (reset)
      !cfg_reg[0].count_enable |=> counter_reg[0] == 8'h00;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("counter not cleared");

  property p_match_clears;
    @(posedge ref_clk) disable iff (reset)
      cfg_reg[0].count_enable && tick[0] && counter_reg[0] == compare_reg[0]
        |=> counter_reg[0] == 8'h00 && match_pulse[0];
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("match did not clear");

  property p_irq_follows;
    @(posedge ref_clk) disable iff (reset)
      match_pulse[1] |=> match_irq_b && status_reg[1];
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("match irq missing");

  property p_count_step;
    @(posedge ref_clk) disable iff (reset)
      cfg_reg[1].count_enable && tick[1] && counter_reg[1] != compare_reg[1]
        |=> counter_reg[1] == $past(counter_reg[1]) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_no_tick_hold;
    @(posedge ref_clk) disable iff (reset)
      cfg_reg[0].count_enable && !tick[0] |=> $stable(counter_reg[0]);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count without tick");

  property p_rise_edge;
    @(posedge ref_clk) disable iff (reset)
      cfg_reg[0].count_enable && cfg_reg[0].clock_sel == 4'h0 && ev_sync_reg[0]
        && !ev_prev_reg[0] && counter_reg[0] != compare_reg[0]
        |=> counter_reg[0] == $past(counter_reg[0]) + 8'h01;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

  property p_div2;
    @(posedge ref_clk) disable iff (reset)
      cfg_reg[0].clock_sel == 4'h5 && !scale_sync_reg && tick[0] |=> !tick[0];
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two wrong");

  property p_sticky;
    @(posedge ref_clk) disable iff (reset)
      status_reg[0] && !(avs_write && avs_address == 5'h18) |=> status_reg[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");

endmodule : interval_event_counter

// *** tb/edge_source.sv ***
// external pulse source model: toggles the timer input pin on command
`timescale 1ns/10ps

module edge_source (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // command from the bench
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic [7:0] gap,
  output logic            busy,
  // timer input pin
  output logic            pin
);
  logic [7:0] left_reg;
  logic [7:0] wait_reg;

  assign busy = (left_reg != 8'h00);

  // pin is driven at all times, so between bursts it holds its last level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      left_reg <= 8'h00;
      wait_reg <= 8'h00;
      pin      <= 1'b0;
    end else if (go && !busy) begin
      left_reg <= n_edges;
      wait_reg <= gap;
    end else if (busy) begin
      if (wait_reg == 8'h00) begin
        pin      <= ~pin;
        left_reg <= left_reg - 8'h01;
        wait_reg <= gap;
      end else begin
        wait_reg <= wait_reg - 8'h01;
      end
    end
  end
endmodule : edge_source

// *** tb/test_interval_event_counter.sv ***
// self-checking bench for the dual interval/event counter
`timescale 1ns/10ps

module test_interval_event_counter;
  // ****************************************
  // signals
  // ****************************************
  logic        ref_clk;
  logic        reset;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        osc_scale_bit;
  logic        event_in_a;
  logic        event_in_b;
  logic        match_irq_a;
  logic        match_irq_b;
  logic        irq;
  logic        go_a;
  logic        go_b;
  logic        busy_a;
  logic        busy_b;
  logic [7:0]  n_edges;
  logic [7:0]  gap;
  logic [31:0] rd;
  int          n_mismatch;
  int          checked;
  int          div;

  // ****************************************
  // design and pulse sources
  // ****************************************
  interval_event_counter dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_scale_bit(osc_scale_bit), .event_in_a(event_in_a), .event_in_b(event_in_b),
    .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .irq(irq));
  edge_source src_a (.ref_clk(ref_clk), .reset(reset), .go(go_a), .n_edges(n_edges),
    .gap(gap), .busy(busy_a), .pin(event_in_a));
  edge_source src_b (.ref_clk(ref_clk), .reset(reset), .go(go_b), .n_edges(n_edges),
    .gap(gap), .busy(busy_b), .pin(event_in_b));

  // ****************************************
  // checks and bus tasks
  // ****************************************
  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic timed_out();
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask : timed_out

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_cycles(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("Error at %0t: interval %0d, expected %0d", $time, got, exp);
    end
  endtask : cmp_cycles

  task automatic cmp_level(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: irq level %b, expected %b", $time, got, exp);
    end
  endtask : cmp_level

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= addr;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= data;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) timed_out();
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [4:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0000_0000);
    cmp_word(rd, exp);
  endtask : rd_chk

  function automatic logic [31:0] mode(input logic en, input logic [3:0] sel,
                                       input logic [6:0] oc);
    mode = 32'h0000_0000;
    mode[interval_counter_pkg::POS_CLOCK_SEL +: 4]  = sel;
    mode[interval_counter_pkg::POS_COUNT_ENABLE]    = en;
    mode[6:0] = oc;
  endfunction : mode

  // stop, load compare, then start: settings never change under a running channel
  task automatic setup(input logic ch, input logic [3:0] sel, input logic [7:0] cmp);
    logic [4:0] m;
    m = ch ? interval_counter_pkg::OFS_MODE_CTRL_B : interval_counter_pkg::OFS_MODE_CTRL_A;
    bus(1'b1, m, mode(1'b0, sel, 7'h00));
    bus(1'b1, ch ? interval_counter_pkg::OFS_COMPARE_B : interval_counter_pkg::OFS_COMPARE_A,
        {24'h000000, cmp});
    bus(1'b1, m, mode(1'b1, sel, 7'h00));
  endtask : setup

  task automatic wait_match(input logic ch, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20000) timed_out();
    end while ((ch ? match_irq_b : match_irq_a) !== 1'b1);
  endtask : wait_match

  // first interval may be short (free-running prescaler), so time the second
  task automatic measure(input logic ch, input int exp);
    int n;
    wait_match(ch, n);
    wait_match(ch, n);
    cmp_cycles(n, exp);
  endtask : measure

  task automatic emit(input logic ch, input logic [7:0] n, input logic [7:0] g);
    int k;
    k = 0;
    @(posedge ref_clk);
    n_edges <= n;
    gap     <= g;
    go_a    <= ~ch;
    go_b    <= ch;
    @(posedge ref_clk);
    go_a <= 1'b0;
    go_b <= 1'b0;
    do begin
      @(posedge ref_clk);
      k++;
      if (k > 500) timed_out();
    end while ((busy_a | busy_b) !== 1'b0);
    repeat (6) @(posedge ref_clk);
  endtask : emit

  // ****************************************
  // clock and test sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    osc_scale_bit = 1'b0;
    go_a = 1'b0;
    go_b = 1'b0;
    n_edges = 8'h00;
    gap = 8'h00;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(interval_counter_pkg::OFS_MODE_CTRL_A, 32'h0000_0000);
    rd_chk(interval_counter_pkg::OFS_COUNTER_B, 32'h0000_0000);
    rd_chk(5'h02, interval_counter_pkg::UNMAPPED_DATA);
    setup(1'b0, 4'h4, 8'h03);
    setup(1'b1, 4'h6, 8'h02);
    measure(1'b0, 4);
    measure(1'b1, 12);
    bus(1'b1, interval_counter_pkg::OFS_MODE_CTRL_A, mode(1'b0, 4'h4, 7'h55));
    bus(1'b1, interval_counter_pkg::OFS_MODE_CTRL_A, mode(1'b1, 4'h4, 7'h55));
    rd_chk(interval_counter_pkg::OFS_MODE_CTRL_A, mode(1'b1, 4'h4, 7'h55));
    measure(1'b0, 4);
    bus(1'b1, interval_counter_pkg::OFS_MODE_CTRL_A, mode(1'b0, 4'h4, 7'h00));
    bus(1'b1, interval_counter_pkg::OFS_MODE_CTRL_B, mode(1'b0, 4'h6, 7'h00));
    rd_chk(interval_counter_pkg::OFS_COUNTER_A, 32'h0000_0000);
    rd_chk(interval_counter_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    cmp_level(irq, 1'b0);
    bus(1'b1, interval_counter_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    cmp_level(irq, 1'b1);
    bus(1'b1, interval_counter_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    cmp_level(irq, 1'b0);
    rd_chk(interval_counter_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    // every internal code at scale 0, codes 0101..1111 at scale 1; prohibited 0100 at scale 1 is skipped
    for (int s = 0; s < 2; s++) begin
      osc_scale_bit <= s[0];
      for (int c = 4 + s; c < 16; c++) begin
        div = (c == 15) ? 4096 : (1 << (c - 4));
        setup(1'b0, c[3:0], 8'h00);
        measure(1'b0, div >> s);
      end
    end
    setup(1'b0, 4'h5, 8'hFF);
    measure(1'b0, 256);
    setup(1'b0, interval_counter_pkg::SEL_EVENT_RISE, 8'h04);
    bus(1'b1, interval_counter_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    emit(1'b0, 8'h01, 8'h06);
    rd_chk(interval_counter_pkg::OFS_COUNTER_A, 32'h0000_0001);
    emit(1'b0, 8'h01, 8'h06);
    rd_chk(interval_counter_pkg::OFS_COUNTER_A, 32'h0000_0001);
    emit(1'b0, 8'h08, 8'h01);
    rd_chk(interval_counter_pkg::OFS_COUNTER_A, 32'h0000_0000);
    rd_chk(interval_counter_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    setup(1'b1, interval_counter_pkg::SEL_EVENT_FALL, 8'h04);
    emit(1'b1, 8'h01, 8'h06);
    rd_chk(interval_counter_pkg::OFS_COUNTER_B, 32'h0000_0000);
    emit(1'b1, 8'h01, 8'h06);
    rd_chk(interval_counter_pkg::OFS_COUNTER_B, 32'h0000_0001);
    final_report();
  end
endmodule : test_interval_event_counter
